// [inc/spks_pkg.sv]
package spks_pkg;
	// ==========================================================
	// timing
	localparam int CLK_MHZ = 100;
	localparam int LONG_PRESS_MS = 1000;
	localparam int LONG_PRESS_CYC = LONG_PRESS_MS * CLK_MHZ * 1000;
	localparam int BLINK_MS = 250;
	localparam int BLINK_CYC = BLINK_MS * CLK_MHZ * 1000;

	// ==========================================================
	// register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATE = 8'h04;
	localparam logic [7:0] OFS_EDIT = 8'h08;
	localparam logic [7:0] OFS_IND = 8'h0c;
	localparam logic [7:0] OFS_SPD_WIN_A = 8'h10;
	localparam logic [7:0] OFS_SPD_WIN_B = 8'h14;
	localparam logic [7:0] OFS_POS_WIN = 8'h18;
	localparam logic [7:0] OFS_ROT_LVL = 8'h1c;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

	// ==========================================================
	// fields and reset values
	localparam int CTRL_JOG = 0;
	localparam int CTRL_PMODE = 1;
	localparam logic [15:0] SPD_WIN_RST = 16'h000a;
	localparam logic [15:0] POS_WIN_RST = 16'h000a;
	localparam logic [15:0] ROT_LVL_RST = 16'h0014;
	localparam logic [2:0] DIG_LAST = 3'h4;
	localparam int IRQ_MODE = 0;
	localparam int IRQ_AXIS = 1;
	localparam int IRQ_ALMCLR = 2;
	localparam int IRQ_EDIT = 3;
	localparam int IRQ_JOG = 4;

	// key slots
	localparam int K_MODE = 0;
	localparam int K_UP = 1;
	localparam int K_DOWN = 2;
	localparam int K_SHIFT = 3;
	localparam int K_SET = 4;
	localparam int K_ARST = 5;

	typedef enum logic [1:0] {
		MD_STATUS, MD_PARAM, MD_MONITOR, MD_AUX
	} spks_mode_t;

	typedef enum logic [2:0] {
		SG_OFF, SG_RUN_A, SG_RUN_B, SG_OT_A, SG_OT_B, SG_ALM_A, SG_ALM_B
	} spks_sign_t;
endpackage

// [hw/spks_key.sv]
`timescale 1ns/100ps
module spks_key #(
	parameter int LONG_CYC = spks_pkg::LONG_PRESS_CYC
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic key_pin,
	output logic press,
	output logic short_rel,
	output logic long_hit,
	output logic level
);
	typedef struct packed {
		logic [2:0] sync;
		logic level;
		logic [31:0] cnt;
		logic press;
		logic short_rel;
		logic long_hit;
	} spks_key_st_t;

	spks_key_st_t st_ff;
	spks_key_st_t nxt_st;

	// ==========================================================
	// sync, filter, hold timer
	always_comb begin
		logic lvl;
		lvl = st_ff.level;
		nxt_st = st_ff;
		nxt_st.sync = {st_ff.sync[1:0], key_pin};
		if (st_ff.sync[1] == st_ff.sync[2]) begin
			lvl = st_ff.sync[2];
		end
		nxt_st.level = lvl;
		nxt_st.press = lvl & ~st_ff.level;
		// released before the hold time: ordinary press
		nxt_st.short_rel = ~lvl & st_ff.level &
			(st_ff.cnt < 32'(LONG_CYC));
		nxt_st.long_hit = lvl & st_ff.level &
			(st_ff.cnt == 32'(LONG_CYC - 1));
		if (!st_ff.level) begin
			nxt_st.cnt = '0;
		end else if (st_ff.cnt != 32'(LONG_CYC)) begin
			nxt_st.cnt = st_ff.cnt + 32'd1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign press = st_ff.press;
	assign short_rel = st_ff.short_rel;
	assign long_hit = st_ff.long_hit;
	assign level = st_ff.level;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	AST_LONG_HOLD: assert property (
		st_ff.long_hit |-> st_ff.level && st_ff.cnt == 32'(LONG_CYC))
		else $error("long press flagged before hold time");
	AST_SHORT_REL: assert property (
		st_ff.short_rel |-> $past(st_ff.cnt) < 32'(LONG_CYC))
		else $error("short release after long hold");
endmodule

// [hw/spks_axis_ind.sv]
`timescale 1ns/100ps
module spks_axis_ind (
	input wire logic servo_on,
	input wire logic pos_mode,
	input wire logic signed [15:0] speed,
	input wire logic signed [15:0] ref_speed,
	input wire logic signed [15:0] pos_dev,
	input wire logic [15:0] spd_win,
	input wire logic [15:0] pos_win,
	input wire logic [15:0] rot_lvl,
	input wire logic fwd_ot,
	input wire logic rev_ot,
	input wire logic blink,
	output logic [3:0] ind
);
	function automatic logic [16:0] mag(input logic [16:0] v);
		return v[16] ? -v : v;
	endfunction

	// ==========================================================
	// one axis worth of indicator segments
	always_comb begin
		logic [16:0] dmag;
		logic [16:0] smag;
		logic [16:0] pmag;
		// one extra bit so the difference cannot wrap
		dmag = mag({speed[15], speed} - {ref_speed[15], ref_speed});
		smag = mag({speed[15], speed});
		pmag = mag({pos_dev[15], pos_dev});
		ind[0] = servo_on;
		if (pos_mode) begin
			ind[1] = pmag < {1'b0, pos_win};
		end else begin
			ind[1] = dmag < {1'b0, spd_win};
		end
		ind[2] = smag > {1'b0, rot_lvl};
		ind[3] = (fwd_ot && rev_ot) ? blink : fwd_ot;
	end
endmodule

// [hw/spks_panel.sv]
// Operation
// - four modes: status, parameter, monitor, auxiliary; short mode press advances cyclically
// - long mode press toggles the axis, A or b
// - mode press is long only when held beyond one second
// - up increments edit value; jog in auxiliary mode starts forward rotation
// - down decrements edit value; jog in auxiliary mode starts reverse rotation
// - shift moves the selected digit left; its decimal point flashes
// - set shows parameter and value and enters editing
// - set in status mode or alarm reset input clears the alarm
// - running indicator lit while axis servo on and motor powered
// - speed mode: second indicator lit when speed error below axis window
// - position mode: second indicator lit when deviation below position window
// - rotation indicator lit when speed exceeds rotation level, every mode
// - overtravel indicator: forward lit, reverse dark, both flashing
// - main power ready indicator lit while main power normal
// - sign shows distinct patterns for all off, A on, b on
// - sign shows per-axis overtravel; direction from that axis indicator
// - alarmed axis sign shows which axis and its alarm number
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/100ps
module spks_panel #(
	parameter int LONG_CYC = spks_pkg::LONG_PRESS_CYC,
	parameter int BLINK_CYC = spks_pkg::BLINK_CYC
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic [2:0] hsize,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic key_mode,
	input wire logic key_up,
	input wire logic key_down,
	input wire logic key_shift,
	input wire logic key_set,
	input wire logic alarm_reset_input,
	input wire logic [1:0] servo_on,
	input wire logic [1:0][15:0] motor_speed,
	input wire logic [1:0][15:0] ref_speed,
	input wire logic [1:0][15:0] pos_dev,
	input wire logic [1:0] forward_overtravel,
	input wire logic [1:0] reverse_overtravel,
	input wire logic main_power_ok,
	input wire logic [1:0] alarm_active,
	input wire logic [1:0][7:0] alarm_code,
	output logic irq,
	output logic [1:0] panel_mode,
	output logic panel_axis,
	output logic editing,
	output logic [4:0] digit_flash,
	output logic [15:0] edit_value,
	output logic [8:0] indicator,
	output logic [2:0] sign_code,
	output logic [7:0] alarm_number,
	output logic jog_forward,
	output logic jog_reverse,
	output logic alarm_clear
);
	typedef struct packed {
		spks_pkg::spks_mode_t mode;
		logic axis;
		logic editing;
		logic [2:0] digit;
		logic [15:0] edit_val;
		logic jog_fwd;
		logic jog_rev;
		logic alm_clr;
		logic [8:0] ind;
		spks_pkg::spks_sign_t sign;
		logic [7:0] alm_no;
		logic [4:0] dp;
		logic blink;
		logic [31:0] bcnt;
		logic [2:0] ctrl;
		logic [1:0][15:0] spd_win;
		logic [15:0] pos_win;
		logic [15:0] rot_lvl;
		logic [4:0] ist;
		logic [4:0] imask;
		logic irq;
		logic ap_wr;
		logic [7:0] ap_addr;
		logic [31:0] rdata;
		logic rdy;
		logic resp;
	} spks_state_t;

	spks_state_t st_ff;
	spks_state_t nxt_st;
	logic [5:0] key_pins;
	logic [5:0] kpress;
	logic [5:0] kshort;
	logic [5:0] klong;
	logic [5:0] klevel;
	logic [1:0][3:0] ind_ax;

	// ==========================================================
	// keys and alarm reset pin: synchronised and timed
	assign key_pins = {alarm_reset_input, key_set, key_shift,
		key_down, key_up, key_mode};

	generate
		for (genvar i = 0; i < 6; i++) begin : g_key
			spks_key #(.LONG_CYC(LONG_CYC)) u_key (
				.clk_sys(clk_sys),
				.rstn(rstn),
				.key_pin(key_pins[i]),
				.press(kpress[i]),
				.short_rel(kshort[i]),
				.long_hit(klong[i]),
				.level(klevel[i])
			);
		end
	endgenerate

	// ==========================================================
	// per-axis indicator evaluation
	generate
		for (genvar a = 0; a < 2; a++) begin : g_ax
			spks_axis_ind u_ind (
				.servo_on(servo_on[a]),
				.pos_mode(st_ff.ctrl[spks_pkg::CTRL_PMODE + a]),
				.speed(motor_speed[a]),
				.ref_speed(ref_speed[a]),
				.pos_dev(pos_dev[a]),
				.spd_win(st_ff.spd_win[a]),
				.pos_win(st_ff.pos_win),
				.rot_lvl(st_ff.rot_lvl),
				.fwd_ot(forward_overtravel[a]),
				.rev_ot(reverse_overtravel[a]),
				.blink(st_ff.blink),
				.ind(ind_ax[a])
			);
		end
	endgenerate

	// ==========================================================
	// next state
	always_comb begin
		logic jog_ctx;
		logic ahit;
		logic [4:0] ev;
		nxt_st = st_ff;
		ev = '0;
		jog_ctx = (st_ff.mode == spks_pkg::MD_AUX) &&
			st_ff.ctrl[spks_pkg::CTRL_JOG];
		ahit = hsel && hready && htrans[1];

		// bus data phase: write lands here
		if (st_ff.ap_wr) begin
			case (st_ff.ap_addr)
				spks_pkg::OFS_CTRL: nxt_st.ctrl = hwdata[2:0];
				spks_pkg::OFS_EDIT: nxt_st.edit_val = hwdata[15:0];
				spks_pkg::OFS_SPD_WIN_A: nxt_st.spd_win[0] = hwdata[15:0];
				spks_pkg::OFS_SPD_WIN_B: nxt_st.spd_win[1] = hwdata[15:0];
				spks_pkg::OFS_POS_WIN: nxt_st.pos_win = hwdata[15:0];
				spks_pkg::OFS_ROT_LVL: nxt_st.rot_lvl = hwdata[15:0];
				spks_pkg::OFS_IRQ_STAT: nxt_st.ist = st_ff.ist & ~hwdata[4:0];
				spks_pkg::OFS_IRQ_MASK: nxt_st.imask = hwdata[4:0];
				default: ;
			endcase
		end

		// bus address phase: read data fetched now, shown next cycle
		nxt_st.ap_wr = 1'b0;
		nxt_st.rdy = 1'b1;
		nxt_st.resp = 1'b0;
		if (ahit) begin
			nxt_st.ap_wr = hwrite && (haddr[31:8] == 24'h000000);
			nxt_st.ap_addr = haddr[7:0];
			nxt_st.rdata = '0;
			if (!hwrite && haddr[31:8] == 24'h000000) begin
				case (haddr[7:0])
					spks_pkg::OFS_CTRL: nxt_st.rdata = {29'h0, st_ff.ctrl};
					spks_pkg::OFS_STATE: nxt_st.rdata = {8'h00, st_ff.alm_no,
						5'h00, st_ff.sign, 1'b0, st_ff.digit, st_ff.editing,
						st_ff.axis, st_ff.mode};
					spks_pkg::OFS_EDIT: nxt_st.rdata = {16'h0, st_ff.edit_val};
					spks_pkg::OFS_IND: nxt_st.rdata = {23'h0, st_ff.ind};
					spks_pkg::OFS_SPD_WIN_A:
						nxt_st.rdata = {16'h0, st_ff.spd_win[0]};
					spks_pkg::OFS_SPD_WIN_B:
						nxt_st.rdata = {16'h0, st_ff.spd_win[1]};
					spks_pkg::OFS_POS_WIN: nxt_st.rdata = {16'h0, st_ff.pos_win};
					spks_pkg::OFS_ROT_LVL: nxt_st.rdata = {16'h0, st_ff.rot_lvl};
					spks_pkg::OFS_IRQ_STAT: nxt_st.rdata = {27'h0, st_ff.ist};
					spks_pkg::OFS_IRQ_MASK: nxt_st.rdata = {27'h0, st_ff.imask};
					default: nxt_st.rdata = '0;
				endcase
			end
		end

		// mode key
		if (kshort[spks_pkg::K_MODE]) begin
			ev[spks_pkg::IRQ_MODE] = 1'b1;
			case (st_ff.mode)
				spks_pkg::MD_STATUS: nxt_st.mode = spks_pkg::MD_PARAM;
				spks_pkg::MD_PARAM: nxt_st.mode = spks_pkg::MD_MONITOR;
				spks_pkg::MD_MONITOR: nxt_st.mode = spks_pkg::MD_AUX;
				default: nxt_st.mode = spks_pkg::MD_STATUS;
			endcase
		end
		if (klong[spks_pkg::K_MODE]) begin
			nxt_st.axis = ~st_ff.axis;
			ev[spks_pkg::IRQ_AXIS] = 1'b1;
		end

		// value edit; up wins when both arrive together
		if (kpress[spks_pkg::K_UP] && !jog_ctx) begin
			nxt_st.edit_val = nxt_st.edit_val + 16'h0001;
			ev[spks_pkg::IRQ_EDIT] = 1'b1;
		end else if (kpress[spks_pkg::K_DOWN] && !jog_ctx) begin
			nxt_st.edit_val = nxt_st.edit_val - 16'h0001;
			ev[spks_pkg::IRQ_EDIT] = 1'b1;
		end

		// jog run only while exactly one direction key is held
		nxt_st.jog_fwd = jog_ctx && klevel[spks_pkg::K_UP] &&
			!klevel[spks_pkg::K_DOWN];
		nxt_st.jog_rev = jog_ctx && klevel[spks_pkg::K_DOWN] &&
			!klevel[spks_pkg::K_UP];
		if ((nxt_st.jog_fwd && !st_ff.jog_fwd) ||
			(nxt_st.jog_rev && !st_ff.jog_rev)) begin
			ev[spks_pkg::IRQ_JOG] = 1'b1;
		end

		if (kpress[spks_pkg::K_SHIFT]) begin
			if (st_ff.digit == spks_pkg::DIG_LAST) begin
				nxt_st.digit = '0;
			end else begin
				nxt_st.digit = st_ff.digit + 3'h1;
			end
		end

		// set: alarm clear in status mode, editing toggled on or off elsewhere
		nxt_st.alm_clr = kpress[spks_pkg::K_ARST] ||
			(kpress[spks_pkg::K_SET] &&
			st_ff.mode == spks_pkg::MD_STATUS);
		if (kpress[spks_pkg::K_SET] && st_ff.mode != spks_pkg::MD_STATUS) begin
			nxt_st.editing = ~st_ff.editing;
			ev[spks_pkg::IRQ_EDIT] = 1'b1;
		end
		ev[spks_pkg::IRQ_ALMCLR] = nxt_st.alm_clr;

		// flash timebase shared by decimal point and overtravel
		if (st_ff.bcnt == 32'(BLINK_CYC - 1)) begin
			nxt_st.bcnt = '0;
			nxt_st.blink = ~st_ff.blink;
		end else begin
			nxt_st.bcnt = st_ff.bcnt + 32'd1;
		end
		nxt_st.dp = (5'h01 << st_ff.digit) & {5{st_ff.blink}};

		nxt_st.ind = {main_power_ok, ind_ax[1], ind_ax[0]};

		// sign priority: alarm, then overtravel, then servo state
		nxt_st.alm_no = '0;
		if (alarm_active[0]) begin
			nxt_st.sign = spks_pkg::SG_ALM_A;
			nxt_st.alm_no = alarm_code[0];
		end else if (alarm_active[1]) begin
			nxt_st.sign = spks_pkg::SG_ALM_B;
			nxt_st.alm_no = alarm_code[1];
		end else if (forward_overtravel[0] || reverse_overtravel[0]) begin
			nxt_st.sign = spks_pkg::SG_OT_A;
		end else if (forward_overtravel[1] || reverse_overtravel[1]) begin
			nxt_st.sign = spks_pkg::SG_OT_B;
		end else if (servo_on[0]) begin
			nxt_st.sign = spks_pkg::SG_RUN_A;
		end else if (servo_on[1]) begin
			nxt_st.sign = spks_pkg::SG_RUN_B;
		end else begin
			nxt_st.sign = spks_pkg::SG_OFF;
		end

		// new events win over a same-cycle clear
		nxt_st.ist = nxt_st.ist | ev;
		nxt_st.irq = |(nxt_st.ist & nxt_st.imask);
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '0;
			st_ff.rdy <= 1'b1;
			st_ff.spd_win <= {spks_pkg::SPD_WIN_RST, spks_pkg::SPD_WIN_RST};
			st_ff.pos_win <= spks_pkg::POS_WIN_RST;
			st_ff.rot_lvl <= spks_pkg::ROT_LVL_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================================
	// outputs
	assign hrdata = st_ff.rdata;
	assign hreadyout = st_ff.rdy;
	assign hresp = st_ff.resp;
	assign irq = st_ff.irq;
	assign panel_mode = st_ff.mode;
	assign panel_axis = st_ff.axis;
	assign editing = st_ff.editing;
	assign digit_flash = st_ff.dp;
	assign edit_value = st_ff.edit_val;
	assign indicator = st_ff.ind;
	assign sign_code = st_ff.sign;
	assign alarm_number = st_ff.alm_no;
	assign jog_forward = st_ff.jog_fwd;
	assign jog_reverse = st_ff.jog_rev;
	assign alarm_clear = st_ff.alm_clr;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	AST_MODE_ADV: assert property (
		kshort[spks_pkg::K_MODE] |=>
		2'(st_ff.mode) == 2'($past(st_ff.mode) + 2'h1))
		else $error("mode did not advance on short press");
	AST_AXIS_TGL: assert property (
		klong[spks_pkg::K_MODE] |=> st_ff.axis != $past(st_ff.axis))
		else $error("axis did not toggle on long press");
	AST_UP_INC: assert property (
		kpress[spks_pkg::K_UP] && !st_ff.ap_wr &&
		!(st_ff.mode == spks_pkg::MD_AUX && st_ff.ctrl[spks_pkg::CTRL_JOG])
		|=> st_ff.edit_val == $past(st_ff.edit_val) + 16'h0001)
		else $error("up did not increment");
	AST_JOG_FWD: assert property (
		st_ff.mode == spks_pkg::MD_AUX && st_ff.ctrl[spks_pkg::CTRL_JOG] &&
		klevel[spks_pkg::K_UP] && !klevel[spks_pkg::K_DOWN]
		|=> st_ff.jog_fwd && !st_ff.jog_rev)
		else $error("jog forward not started");
	AST_DOWN_DEC: assert property (
		kpress[spks_pkg::K_DOWN] && !kpress[spks_pkg::K_UP] &&
		!st_ff.ap_wr && st_ff.mode != spks_pkg::MD_AUX
		|=> st_ff.edit_val == $past(st_ff.edit_val) - 16'h0001)
		else $error("down did not decrement");
	AST_SHIFT: assert property (
		kpress[spks_pkg::K_SHIFT] |=> st_ff.digit ==
		(($past(st_ff.digit) == 3'h4) ? 3'h0 : $past(st_ff.digit) + 3'h1))
		else $error("digit did not shift left");
	AST_SET_EDIT: assert property (
		kpress[spks_pkg::K_SET] && st_ff.mode != spks_pkg::MD_STATUS
		|=> st_ff.editing != $past(st_ff.editing) && !st_ff.alm_clr)
		else $error("set did not toggle editing");
	AST_ALM_CLR: assert property (
		(kpress[spks_pkg::K_SET] && st_ff.mode == spks_pkg::MD_STATUS) ||
		kpress[spks_pkg::K_ARST] |=> st_ff.alm_clr ##1 !st_ff.alm_clr ||
		$past(kpress[spks_pkg::K_ARST]))
		else $error("alarm clear pulse wrong");
	AST_PWR_IND: assert property (
		$fell(main_power_ok) |=> !st_ff.ind[8])
		else $error("power ready stays lit");
	AST_ALM_SIGN: assert property (
		alarm_active[0] |=> st_ff.sign == spks_pkg::SG_ALM_A &&
		st_ff.alm_no == $past(alarm_code[0]))
		else $error("axis A alarm sign wrong");
	AST_IRQ: assert property (
		st_ff.alm_clr && st_ff.imask[spks_pkg::IRQ_ALMCLR] |-> st_ff.irq)
		else $error("alarm clear event did not raise interrupt");

	COV_AUX: cover property (st_ff.mode == spks_pkg::MD_AUX);
	COV_AXIS: cover property (klong[spks_pkg::K_MODE] ##1 st_ff.axis);
	COV_JOG: cover property (st_ff.jog_fwd);
	COV_CLR: cover property (st_ff.alm_clr);
endmodule

// [testbench/spks_operator.sv]
`timescale 1ns/100ps
// ==========================================================
// keypad operator: keys change only just after a rising edge
module spks_operator (
	input wire logic clk_sys,
	output logic [5:0] keys
);
	initial keys = 6'h00;
	task automatic hold(input int k);
		@(posedge clk_sys);
		keys[k] <= 1'b1;
	endtask
	// settle time covers the synchroniser and filter of the panel
	task automatic free(input int k);
		@(posedge clk_sys);
		keys[k] <= 1'b0;
		repeat (10) @(posedge clk_sys);
	endtask
	task automatic tap(input int k, input int n);
		hold(k);
		repeat (n) @(posedge clk_sys);
		free(k);
	endtask
endmodule

// [testbench/tb_spks_panel.sv]
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
	miscompares++; $display("wrong value %s exp %0h got %0h", nm, ex, gt); \
	end end
module tb_spks_panel;
	localparam int LONG = 20;
	logic clk_sys, rstn, hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, servo_on, forward_overtravel, reverse_overtravel;
	logic [1:0] alm, panel_mode;
	logic [2:0] hsize, sign_code;
	logic [1:0][15:0] spd, rspd, pdev;
	logic [1:0][7:0] acode;
	logic mpok, panel_axis, editing, jog_forward, jog_reverse, alarm_clear;
	logic [4:0] digit_flash;
	logic [15:0] edit_value;
	logic [8:0] indicator;
	logic [7:0] alarm_number;
	logic [5:0] keys;
	int miscompares, checks_done, clr_cnt, i;
	bit s0, s1;

	spks_operator spks_operator_inst (.clk_sys(clk_sys), .keys(keys));
	spks_panel #(.LONG_CYC(LONG), .BLINK_CYC(8)) spks_panel_inst (
		.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hsize(hsize), .hwrite(hwrite), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .key_mode(keys[0]), .key_up(keys[1]),
		.key_down(keys[2]), .key_shift(keys[3]), .key_set(keys[4]),
		.alarm_reset_input(keys[5]), .servo_on(servo_on),
		.motor_speed(spd), .ref_speed(rspd), .pos_dev(pdev),
		.forward_overtravel(forward_overtravel),
		.reverse_overtravel(reverse_overtravel), .main_power_ok(mpok),
		.alarm_active(alm), .alarm_code(acode), .irq(irq),
		.panel_mode(panel_mode), .panel_axis(panel_axis),
		.editing(editing), .digit_flash(digit_flash),
		.edit_value(edit_value), .indicator(indicator),
		.sign_code(sign_code), .alarm_number(alarm_number),
		.jog_forward(jog_forward), .jog_reverse(jog_reverse),
		.alarm_clear(alarm_clear));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// pulses last one cycle, so they are counted rather than polled
	always @(posedge clk_sys) begin
		if (alarm_clear === 1'b1)
			clr_cnt++;
	end

	// ==========================================================
	// bus and check tasks
	// no local limit: only the watchdog may end a wait
	task automatic wait_rdy();
		do begin
			@(posedge clk_sys);
		end while (hreadyout !== 1'b1);
	endtask
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] ex);
		ahb(1'b0, a, 32'h00000000);
		`CHK(nm, ex, rd)
		`CHK("hresp", 1'b0, hresp)
	endtask
	task automatic ind(input logic [8:0] ei, input logic [2:0] es);
		repeat (3) @(posedge clk_sys);
		`CHK("indicator", ei, indicator)
		`CHK("sign", es, sign_code)
	endtask
	task automatic blink(input int sel);
		s0 = 1'b0;
		s1 = 1'b0;
		repeat (24) begin
			@(posedge clk_sys);
			if ((sel ? indicator[3] : digit_flash[0]) === 1'b0)
				s0 = 1'b1;
			if ((sel ? indicator[3] : digit_flash[0]) === 1'b1)
				s1 = 1'b1;
		end
		`CHK("flash", 1'b1, s0 & s1)
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#100000;
		miscompares++;
		summarize();
	end

	// ==========================================================
	// tests
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
		hsize = 3'h2;
		{servo_on, forward_overtravel, reverse_overtravel, alm} = '0;
		{spd, rspd, pdev, acode, mpok, clr_cnt} = '0;
		rstn = 1'b0;
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rchk("spd_a", spks_pkg::OFS_SPD_WIN_A, 32'h0000000a);
		rchk("spd_b", spks_pkg::OFS_SPD_WIN_B, 32'h0000000a);
		rchk("pos", spks_pkg::OFS_POS_WIN, 32'h0000000a);
		rchk("rot", spks_pkg::OFS_ROT_LVL, 32'h00000014);
		rchk("mask", spks_pkg::OFS_IRQ_MASK, 32'h00000000);
		ahb(1'b1, 8'h40, 32'hffffffff);
		rchk("unmapped", 8'h40, 32'h00000000);
		ahb(1'b1, spks_pkg::OFS_SPD_WIN_B, 32'h00000020);
		rchk("spd_b", spks_pkg::OFS_SPD_WIN_B, 32'h00000020);
		ahb(1'b1, spks_pkg::OFS_IRQ_MASK, 32'h00000001);
		for (i = 1; i <= 4; i++) begin
			spks_operator_inst.tap(spks_pkg::K_MODE, 4);
			`CHK("mode", 2'(i % 4), panel_mode)
		end
		`CHK("irq", 1'b1, irq)
		rchk("stat", spks_pkg::OFS_IRQ_STAT, 32'h00000001);
		ahb(1'b1, spks_pkg::OFS_IRQ_STAT, 32'h0000001f);
		repeat (2) @(posedge clk_sys);
		`CHK("irq", 1'b0, irq)
		spks_operator_inst.tap(spks_pkg::K_MODE, LONG + 10);
		`CHK("axis", 1'b1, panel_axis)
		`CHK("mode", 2'h0, panel_mode)
		spks_operator_inst.tap(spks_pkg::K_MODE, LONG - 5);
		`CHK("axis", 1'b1, panel_axis)
		`CHK("mode", 2'h1, panel_mode)
		ahb(1'b1, spks_pkg::OFS_EDIT, 32'h00000005);
		spks_operator_inst.tap(spks_pkg::K_SET, 4);
		`CHK("editing", 1'b1, editing)
		spks_operator_inst.tap(spks_pkg::K_UP, 4);
		`CHK("edit", 16'h0006, edit_value)
		spks_operator_inst.tap(spks_pkg::K_DOWN, 4);
		spks_operator_inst.tap(spks_pkg::K_DOWN, 4);
		`CHK("edit", 16'h0004, edit_value)
		for (i = 1; i <= 5; i++) begin
			spks_operator_inst.tap(spks_pkg::K_SHIFT, 4);
			ahb(1'b0, spks_pkg::OFS_STATE, 32'h00000000);
			`CHK("digit", 3'(i % 5), rd[6:4])
		end
		blink(0);
		spks_operator_inst.tap(spks_pkg::K_SET, 4);
		`CHK("editing", 1'b0, editing)
		spks_operator_inst.tap(spks_pkg::K_MODE, 4);
		spks_operator_inst.tap(spks_pkg::K_MODE, 4);
		ahb(1'b1, spks_pkg::OFS_CTRL, 32'h00000001);
		spks_operator_inst.hold(spks_pkg::K_UP);
		repeat (8) @(posedge clk_sys);
		`CHK("jog_f", 2'h2, {jog_forward, jog_reverse})
		spks_operator_inst.free(spks_pkg::K_UP);
		spks_operator_inst.hold(spks_pkg::K_DOWN);
		repeat (8) @(posedge clk_sys);
		`CHK("jog_r", 2'h1, {jog_forward, jog_reverse})
		spks_operator_inst.free(spks_pkg::K_DOWN);
		`CHK("edit", 16'h0004, edit_value)
		ahb(1'b1, spks_pkg::OFS_CTRL, 32'h00000000);
		spks_operator_inst.tap(spks_pkg::K_MODE, 4);
		ahb(1'b1, spks_pkg::OFS_IRQ_STAT, 32'h0000001f);
		ahb(1'b1, spks_pkg::OFS_IRQ_MASK, 32'h00000004);
		spks_operator_inst.tap(spks_pkg::K_SET, 4);
		`CHK("clears", 1, clr_cnt)
		`CHK("irq", 1'b1, irq)
		rchk("stat", spks_pkg::OFS_IRQ_STAT, 32'h00000004);
		`CHK("editing", 1'b0, editing)
		spks_operator_inst.tap(spks_pkg::K_ARST, 4);
		`CHK("clears", 2, clr_cnt)
		servo_on <= 2'h1;
		spd <= {16'h001e, 16'h0064};
		rspd <= {16'h0000, 16'h005f};
		forward_overtravel <= 2'h1;
		mpok <= 1'b1;
		ind(9'h16f, 3'h3);
		ahb(1'b1, spks_pkg::OFS_CTRL, 32'h00000002);
		servo_on <= 2'h2;
		spd[0] <= 16'h0014;
		pdev[0] <= 16'h000a;
		forward_overtravel <= 2'h0;
		reverse_overtravel <= 2'h1;
		mpok <= 1'b0;
		ind(9'h070, 3'h3);
		pdev[0] <= 16'h0009;
		reverse_overtravel <= 2'h0;
		mpok <= 1'b1;
		ind(9'h172, 3'h2);
		for (i = 0; i < 3; i++) begin
			servo_on <= 2'(i);
			ind({1'b1, 3'b011, i[1], 3'b001, i[0]}, 3'(i));
		end
		forward_overtravel <= 2'h1;
		reverse_overtravel <= 2'h1;
		blink(1);
		alm <= 2'h2;
		acode <= {8'h2a, 8'h07};
		repeat (3) @(posedge clk_sys);
		`CHK("alarm", 11'h62a, {sign_code, alarm_number})
		alm <= 2'h3;
		repeat (3) @(posedge clk_sys);
		`CHK("alarm", 11'h507, {sign_code, alarm_number})
		summarize();
	end
endmodule
